// ### hw/rst_ctrl_consts.svh
`ifndef RST_CTRL_CONSTS_SVH
`define RST_CTRL_CONSTS_SVH
// Register map, one byte register per address
`define ADDR_WD_CTRL 4'h0
`define ADDR_VOLT_SEL 4'h1
`define ADDR_RST_FLAGS 4'h2
`define ADDR_STATUS 4'h3
`define ADDR_CMD 4'h4
// Reset values
`define WD_CTRL_POR 8'h53
`define VOLT_SEL_POR 8'h55
// Field positions in the watchdog control register
`define KEY_MSB 7
`define KEY_LSB 3
`define SEL_MSB 2
`define SEL_LSB 0
// Key field values
`define KEY_A 5'h15
`define KEY_B 5'h0A
// Threshold codes
`define LVL_2V1 8'h55
`define LVL_2V55 8'h33
`define LVL_3V15 8'h99
`define LVL_3V8 8'hAA
// Flag bit positions in reset_source_flags
`define BIT_IDLE_KEEP 7
`define BIT_LV_FLAG 2
`define BIT_VS_FAULT 1
`define BIT_KEY_FAULT 0
// Status bit positions
`define BIT_TIMEOUT 0
`define BIT_POWERDOWN 1
`define BIT_IN_RESET 2
`define BIT_SLEEP 3
// Command bits
`define CMD_CLEAR 0
`define CMD_HALT 1
`define CMD_WAKE 2
// Timing: system clock period in ns, delays in us
`define SYS_PERIOD_NS 100
`define POR_DELAY_US 50000
`define WDR_DELAY_US 16700
`define POR_CYCLES ((`POR_DELAY_US * 1000) / `SYS_PERIOD_NS)
`define WDR_CYCLES ((`WDR_DELAY_US * 1000) / `SYS_PERIOD_NS)
// Sub-clock cycles before a fault reset takes effect (2~3, we use 3)
`define FAULT_SUB_CYCLES 2'h3
`define SETTLE_FAST 8'h10
`define SETTLE_XTAL 8'h80
`define SETTLE_SLOW 8'h02
`define CNT_W 23
`endif

// ### hw/rst_ctrl_pkg.sv
package rst_ctrl_pkg;
   typedef enum logic [1:0] {
      OSC_FAST_INT,
      OSC_FAST_XTAL,
      OSC_SLOW_INT,
      OSC_SLOW_XTAL
   } osc_src_t;
   typedef enum {
      ST_HOLD,
      ST_RUN,
      ST_SETTLE
   } seq_state_t;
endpackage

// ### hw/watchdog_and_reset_control.sv
// Contract
// R1: Watchdog overflow resets the device; software clears it before overflow.
// R2: Key field 10101 or 01010 enables watchdog; other values reset the chip.
// R3: Timeout in normal mode gives full reset like undervoltage and sets timeout_flag.
// R4: Timeout in sleep or idle sets timeout_flag and clears only PC and SP.
// R5: Counter cleared by key reset, clear instruction, or halt instruction.
// R6: Program counter is zero after power-on reset.
// R7: Port data and control registers power up high, pins as inputs.
// R8: Power-on reset held for release delay of 50 ms.
// R9: Valid undervoltage resets the device and sets lowvolt_reset_flag.
// R10: Undervoltage reset only if low supply persists beyond validity time.
// R11: volt_level_select codes pick 2.1, 2.55, 3.15 or 3.8 volt threshold.
// R12: Undefined level code resets after 2~3 sub cycles, sets fault, restores value.
// R13: volt_threshold_select powers up as 01010101.
// R14: Real undervoltage reset follows after 2~3 sub cycles, register kept.
// R15: Undervoltage reset disabled in power-down mode.
// R16: lowvolt_reset_flag set by hardware, cleared only by software.
// R17: volt_select_fault_flag set on undefined code, cleared by writing zero.
// R18: reset_source_flags bits 6 to 3 read as zero.
// R19: Normal-mode watchdog reset held for release delay of 16.7 ms.
// R20: Wake from sleep waits settle time: 16, 128 or 2 cycles per oscillator. Only the watchdog wake settles; the wake command skips it.
// R21: timeout_select picks sub clock divided by 2^8 up to 2^18.
// R22: Invalid key resets after 2~3 sub cycles and sets wd_key_fault_flag.
// R23: wd_key_fault_flag set only by key reset, cleared only by software.
// R24: Watchdog counter advances on the sub clock tick.
// R25: Power-on clears timeout and powerdown flags; undervoltage leaves them.
//
// The address map and the strobed register port were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "rst_ctrl_consts.svh"
module watchdog_and_reset_control
   import rst_ctrl_pkg::*;
#(
   parameter int POR_CNT = `POR_CYCLES,
   parameter int WDR_CNT = `WDR_CYCLES
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic subTick,
   input wire logic [1:0] oscSrc,
   input wire logic lowSupply,
   input wire logic lowSupplyValid,
   input wire logic [3:0] regAddr,
   input wire logic [7:0] regWdata,
   input wire logic regWrite,
   input wire logic regRead,
   output logic [7:0] regRdata,
   output logic sysResetN,
   output logic pcSpClear,
   output logic portsToInput,
   output logic [7:0] thresholdSel
);
   // =========================================
   // Decode helpers
   function automatic logic levelValid(input logic [7:0] v);
      levelValid = (v == `LVL_2V1) || (v == `LVL_2V55) || (v == `LVL_3V15) || (v == `LVL_3V8);
   endfunction

   function automatic logic [4:0] divExp(input logic [2:0] s);
      case (s)
         3'h0: divExp = 5'h08;
         3'h1: divExp = 5'h0A;
         3'h2: divExp = 5'h0C;
         3'h3: divExp = 5'h0E;
         default: divExp = 5'(5'h0B + {2'h0, s});
      endcase
   endfunction

   // =========================================
   // Fault timing and flag helpers
   // Fault wait counter: one step per sub tick while the fault lasts
   function automatic logic [1:0] waitStep(input logic hold, input logic tick, input logic [1:0] w);
      if (!hold) begin
         waitStep = 2'h0;
      end else if (tick) begin
         waitStep = 2'(w + 2'h1);
      end else begin
         waitStep = w;
      end
   endfunction

   // Last wait step before a fault reset fires
   function automatic logic waitDone(input logic [1:0] w);
      waitDone = (w == 2'(`FAULT_SUB_CYCLES - 2'h1));
   endfunction

   // Sticky flag: a hardware set wins, software clears only by writing zero
   function automatic logic stickyNext(input logic set, input logic wr, input logic wbit,
                                       input logic q);
      stickyNext = set || (q && !(wr && !wbit));
   endfunction

   // Clock settle length per system oscillator
   function automatic logic [7:0] settleOf(input logic [1:0] src);
      case (src)
         OSC_FAST_INT: settleOf = `SETTLE_FAST;
         OSC_SLOW_INT: settleOf = `SETTLE_SLOW;
         default: settleOf = `SETTLE_XTAL;
      endcase
   endfunction

   // =========================================
   // Registers
   logic [7:0] wdCtrl_q;
   logic [7:0] voltSel_q;
   logic idleKeep_q, lvFlag_q, vsFault_q, keyFault_q;
   logic timeout_q, powerdown_q, sleep_q;
   logic [17:0] wdCnt_q;
   logic [1:0] keyWait_q, vsWait_q, lvWait_q;
   logic [22:0] holdCnt_q;
   logic [7:0] settleCnt_q;
   logic [7:0] rdata_q;
   seq_state_t state_q;
   logic porDone_q;
   logic lvPend_q;
   // Hold loads; 23 bits cover the power-on delay at the 10 MHz clock
   localparam logic [22:0] POR_LOAD = 23'(POR_CNT - 1);
   localparam logic [22:0] WDR_LOAD = 23'(WDR_CNT - 1);

   wire wrWd = regWrite && (regAddr == `ADDR_WD_CTRL);
   wire wrVs = regWrite && (regAddr == `ADDR_VOLT_SEL);
   wire wrFl = regWrite && (regAddr == `ADDR_RST_FLAGS);
   wire wrCmd = regWrite && (regAddr == `ADDR_CMD);
   wire cmdClear = wrCmd && regWdata[`CMD_CLEAR];
   wire cmdHalt = wrCmd && regWdata[`CMD_HALT];
   wire cmdWake = wrCmd && regWdata[`CMD_WAKE];
   wire running = (state_q == ST_RUN);

   // R2: key decode
   wire [4:0] key = wdCtrl_q[`KEY_MSB:`KEY_LSB];
   wire keyOk = (key == `KEY_A) || (key == `KEY_B);
   wire vsOk = levelValid(voltSel_q);
   // R21: period select
   wire [2:0] wdSel = wdCtrl_q[`SEL_MSB:`SEL_LSB];
   wire [4:0] expo = divExp(wdSel);
   wire [17:0] lastCnt = 18'((19'h1 << expo) - 19'h1);
   // R1: overflow
   wire wdOverflow = running && keyOk && subTick && (wdCnt_q == lastCnt);
   // R10: only a validated low supply counts; R15: not while powered down
   // Limitation: a low supply seen during sleep is not remembered after wake
   wire lvDetect = lowSupply && lowSupplyValid && !sleep_q;
   // R22: key fault fires after counted sub ticks
   wire keyFire = running && !keyOk && subTick && waitDone(keyWait_q);
   // R12: level fault after counted sub ticks
   wire vsFire = running && !vsOk && subTick && waitDone(vsWait_q);
   // R14: undervoltage reset after counted sub ticks
   wire lvFire = running && lvPend_q && subTick && waitDone(lvWait_q);
   wire wdNormal = wdOverflow && !sleep_q;
   wire wdSleep = wdOverflow && sleep_q;
   wire fullReset = keyFire || vsFire || lvFire || wdNormal;

   wire [7:0] settleLen = settleOf(oscSrc);

   // =========================================
   // Watchdog control register and counter
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         wdCtrl_q <= `WD_CTRL_POR;
      end else if (keyFire) begin
         wdCtrl_q <= `WD_CTRL_POR;
      end else if (wrWd) begin
         wdCtrl_q <= regWdata;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         wdCnt_q <= 18'h0;
      // R5: three clear sources, plus any reset
      // A bad key holds the count at zero until the key fault reset restores the power-on value
      end else if (!running || cmdClear || cmdHalt || !keyOk || wdOverflow) begin
         wdCnt_q <= 18'h0;
      // R24: advance on sub clock
      end else if (subTick) begin
         wdCnt_q <= wdCnt_q + 18'h1;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         keyWait_q <= 2'h0;
         vsWait_q <= 2'h0;
         lvWait_q <= 2'h0;
         lvPend_q <= 1'b0;
      end else begin
         keyWait_q <= waitStep(!keyOk && running, subTick, keyWait_q);
         vsWait_q <= waitStep(!vsOk && running, subTick, vsWait_q);
         // A pending undervoltage is dropped by any reset, which already covers it
         lvPend_q <= running && (lvPend_q || lvDetect) && !lvFire;
         lvWait_q <= waitStep(lvPend_q, subTick, lvWait_q);
      end
   end

   // =========================================
   // Level select register
   always_ff @(posedge clk or negedge resetn) begin
      // R13: power-on value
      if (!resetn) begin
         voltSel_q <= `VOLT_SEL_POR;
      // R12: restored on fault; R14: undervoltage keeps it
      end else if (vsFire) begin
         voltSel_q <= `VOLT_SEL_POR;
      end else if (wrVs) begin
         voltSel_q <= regWdata;
      end
   end

   // =========================================
   // Source flags; a hardware set wins over a software clear
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         idleKeep_q <= 1'b0;
         lvFlag_q <= 1'b0;
         vsFault_q <= 1'b0;
         keyFault_q <= 1'b0;
      end else begin
         if (wrFl) begin
            idleKeep_q <= regWdata[`BIT_IDLE_KEEP];
         end
         // R9: set on undervoltage; R16: software clear only
         lvFlag_q <= stickyNext(lvFire, wrFl, regWdata[`BIT_LV_FLAG], lvFlag_q);
         // R17: set on undefined code
         vsFault_q <= stickyNext(vsFire, wrFl, regWdata[`BIT_VS_FAULT], vsFault_q);
         // R23: set only by key reset
         keyFault_q <= stickyNext(keyFire, wrFl, regWdata[`BIT_KEY_FAULT], keyFault_q);
      end
   end

   // =========================================
   // Status flags and power mode
   always_ff @(posedge clk or negedge resetn) begin
      // R25: power-on clears both
      if (!resetn) begin
         timeout_q <= 1'b0;
         powerdown_q <= 1'b0;
         sleep_q <= 1'b0;
      end else begin
         // R3: R4: timeout sets flag in both modes
         if (wdOverflow) begin
            timeout_q <= 1'b1;
         end else if (cmdHalt && running) begin
            timeout_q <= 1'b0;
         end
         // Halt is taken only while running; a halt during a hold is lost
         if (cmdHalt && running) begin
            powerdown_q <= 1'b1;
         end else if (cmdClear) begin
            powerdown_q <= 1'b0;
         end
         if (cmdHalt && running) begin
            sleep_q <= 1'b1;
         end else if (wdSleep || cmdWake || fullReset) begin
            sleep_q <= 1'b0;
         end
      end
   end

   // =========================================
   // Reset sequencer
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         state_q <= ST_HOLD;
         // R8: power-on hold runs the long delay
         holdCnt_q <= POR_LOAD;
         settleCnt_q <= 8'h0;
         porDone_q <= 1'b0;
      end else begin
         case (state_q)
            // R8: R19: hold for release delay
            ST_HOLD: begin
               if (holdCnt_q == 23'h0) begin
                  state_q <= ST_RUN;
                  porDone_q <= 1'b1;
               end else begin
                  holdCnt_q <= holdCnt_q - 23'h1;
               end
            end
            ST_RUN: begin
               if (fullReset) begin
                  state_q <= ST_HOLD;
                  holdCnt_q <= WDR_LOAD;
               // R20: settle after wake reset
               end else if (wdSleep) begin
                  state_q <= ST_SETTLE;
                  settleCnt_q <= settleLen - 8'h1;
               end
            end
            ST_SETTLE: begin
               if (settleCnt_q == 8'h0) begin
                  state_q <= ST_RUN;
               end else begin
                  settleCnt_q <= settleCnt_q - 8'h1;
               end
            end
            default: state_q <= ST_HOLD;
         endcase
      end
   end

   // =========================================
   // Read path
   wire [7:0] flagsRd = {idleKeep_q, 4'h0, lvFlag_q, vsFault_q, keyFault_q};
   wire [7:0] statusRd = {4'h0, sleep_q, !running, powerdown_q, timeout_q};
   // Unmapped addresses read zero rather than a stale value
   // R18: bits 6..3 read zero
   wire [7:0] rdMux = (regAddr == `ADDR_WD_CTRL) ? wdCtrl_q :
                      (regAddr == `ADDR_VOLT_SEL) ? voltSel_q :
                      (regAddr == `ADDR_RST_FLAGS) ? flagsRd :
                      (regAddr == `ADDR_STATUS) ? statusRd : 8'h00;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rdata_q <= 8'h00;
      end else begin
         rdata_q <= regRead ? rdMux : 8'h00;
      end
   end

   // =========================================
   // Outputs
   logic resetOut_q, pcSp_q, portsIn_q;
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         resetOut_q <= 1'b0;
         pcSp_q <= 1'b1;
         portsIn_q <= 1'b1;
      end else begin
         // R4: a watchdog wake from sleep settles the clock without resetting the device
         resetOut_q <= (state_q != ST_HOLD) && !fullReset;
         // R4: R6: PC and SP cleared by any reset or watchdog wake
         pcSp_q <= (state_q != ST_RUN) || fullReset || wdSleep;
         // R7: ports to input until the power-on hold ends
         portsIn_q <= !porDone_q;
      end
   end

   assign regRdata = rdata_q;
   assign sysResetN = resetOut_q;
   assign pcSpClear = pcSp_q;
   assign portsToInput = portsIn_q;
   // R11: threshold code to the comparator
   assign thresholdSel = voltSel_q;
endmodule
`default_nettype wire

// ### verification/rst_ctrl_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module rst_ctrl_chk #(
   parameter int POR_CNT = 4,
   parameter int WDR_CNT = 20
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic subTick,
   input wire logic [3:0] regAddr,
   input wire logic [7:0] regWdata,
   input wire logic regWrite,
   input wire logic regRead,
   input wire logic [7:0] regRdata,
   input wire logic sysResetN,
   input wire logic pcSpClear,
   input wire logic [7:0] thresholdSel
);
   // ========
   // Helpers
   // Hold length is counted here; a long repetition would not unroll
   int lowCnt;
   logic porSeen;
   wire logic okThr;
   assign okThr = thresholdSel inside {8'h55, 8'h33, 8'h99, 8'hAA};
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         lowCnt <= 0;
         porSeen <= 1'b0;
      end else begin
         lowCnt <= sysResetN ? 0 : lowCnt + 1;
         porSeen <= porSeen || sysResetN;
      end
   end
   default clocking @(posedge clk);
   endclocking
   default disable iff (!resetn);
   // ========
   // Properties
   chk_rsvd_zero: assert property (
      $past(regRead) && $past(regAddr) == 4'h2 |-> regRdata[6:3] == 4'h0)
      else $error("reserved flag bits set");
   chk_thr_write: assert property (
      $past(regWrite) && $past(regAddr) == 4'h1 && $past(sysResetN)
      && $past(regWdata) inside {8'h55, 8'h33, 8'h99, 8'hAA}
      |-> thresholdSel == $past(regWdata))
      else $error("threshold write lost");
   chk_thr_defined: assert property (
      $rose(sysResetN) |-> okThr)
      else $error("undefined threshold after reset");
   // Restores from a bad code are excluded, they may land before the reset
   chk_thr_stable: assert property (
      !$past(regWrite) && $past(okThr) && $past(sysResetN) |-> $stable(thresholdSel))
      else $error("threshold changed without write");
   chk_fall_tick: assert property (
      $fell(sysResetN) |-> $past(subTick) || $past(subTick, 2))
      else $error("reset not after a sub tick");
   chk_hold_len: assert property (
      $rose(sysResetN) && porSeen |-> lowCnt inside {[WDR_CNT:WDR_CNT + 1]})
      else $error("reset hold length wrong");
   chk_por_len: assert property (
      $rose(sysResetN) && !porSeen |-> lowCnt inside {[POR_CNT:POR_CNT + 1]})
      else $error("power-on hold length wrong");
   chk_sleep_keep: assert property (
      $rose(pcSpClear) && sysResetN |-> ##1 sysResetN [*4])
      else $error("sleep wake gave full reset");
   chk_pc_clear: assert property (
      !sysResetN |-> pcSpClear)
      else $error("counter not cleared in reset");
   cover property ($rose(sysResetN) && lowCnt > 2);
   cover property ($rose(pcSpClear) && sysResetN);
   cover property ($past(regRead) && regRdata[2:0] != 3'h0);
endmodule
bind watchdog_and_reset_control rst_ctrl_chk #(.POR_CNT(POR_CNT), .WDR_CNT(WDR_CNT)) chk (
   .clk(clk),
   .resetn(resetn),
   .subTick(subTick),
   .regAddr(regAddr),
   .regWdata(regWdata),
   .regWrite(regWrite),
   .regRead(regRead),
   .regRdata(regRdata),
   .sysResetN(sysResetN),
   .pcSpClear(pcSpClear),
   .thresholdSel(thresholdSel)
);
`default_nettype wire

// ### verification/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb
   import rst_ctrl_pkg::*;
;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic subTick = 1'b0;
   logic [1:0] oscSrc = 2'h0;
   logic lowSupply = 1'b0;
   logic lowSupplyValid = 1'b0;
   logic [3:0] regAddr = 4'h0;
   logic [7:0] regWdata = 8'h00;
   logic regWrite = 1'b0;
   logic regRead = 1'b0;
   wire logic [7:0] regRdata;
   wire logic sysResetN;
   wire logic pcSpClear;
   wire logic portsToInput;
   wire logic [7:0] thresholdSel;
   logic tickAll = 1'b0;
   logic rdLast = 1'b0;
   logic [7:0] expQ[$];
   logic [7:0] mskQ[$];
   logic [7:0] codes[4] = '{8'h55, 8'h33, 8'h99, 8'hAA};
   // Wake pulse on pcSpClear: settle time per oscillator plus the wake cycle
   int setLo[4] = '{16, 129, 2, 129};
   int setHi[4] = '{17, 129, 3, 129};
   int bad_count = 0;
   int num_checks = 0;
   int falls = 0;
   int seed = 35;
   int f;
   int n;
   int k;
   watchdog_and_reset_control #(.POR_CNT(4), .WDR_CNT(20)) dut (
      .clk(clk),
      .resetn(resetn),
      .subTick(subTick),
      .oscSrc(oscSrc),
      .lowSupply(lowSupply),
      .lowSupplyValid(lowSupplyValid),
      .regAddr(regAddr),
      .regWdata(regWdata),
      .regWrite(regWrite),
      .regRead(regRead),
      .regRdata(regRdata),
      .sysResetN(sysResetN),
      .pcSpClear(pcSpClear),
      .portsToInput(portsToInput),
      .thresholdSel(thresholdSel)
   );
   // ========
   // Tasks
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic chk1(input logic got, input logic exp);
      chk8({7'h00, got}, {7'h00, exp});
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      regAddr <= a;
      regWdata <= d;
      regWrite <= 1'b1;
      @(posedge clk);
      regWrite <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [7:0] e, input logic [7:0] m);
      @(posedge clk);
      regAddr <= a;
      regRead <= 1'b1;
      expQ.push_back(e);
      mskQ.push_back(m);
      @(posedge clk);
      regRead <= 1'b0;
   endtask
   task automatic waitR(input logic lv);
      n = 0;
      while (sysResetN !== lv && n < 500) begin
         @(negedge clk);
         n++;
      end
      chk1(sysResetN, lv);
   endtask
   task automatic finish_test();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   initial forever #50 clk = ~clk;
   always @(posedge clk) subTick <= tickAll | (($random(seed) & 3) == 0);
   always @(posedge clk) rdLast <= regRead;
   always @(negedge sysResetN) falls++;
   // Read data stand one cycle only, so they are taken mid-cycle
   always @(negedge clk) begin
      if (rdLast) begin
         chk8(regRdata & mskQ.pop_front(), expQ.pop_front());
      end
   end
   initial begin
      repeat (20000) @(posedge clk);
      bad_count++;
      finish_test();
   end
   // ========
   // Sequence
   initial begin
      repeat (12) @(posedge clk);
      chk1(sysResetN, 1'b0);
      chk1(pcSpClear, 1'b1);
      chk1(portsToInput, 1'b1);
      resetn <= 1'b1;
      waitR(1'b1);
      @(negedge clk);
      chk1(portsToInput, 1'b0);
      chk8(thresholdSel, 8'h55);
      rd(4'h0, 8'h53, 8'hFF);
      rd(4'h1, 8'h55, 8'hFF);
      rd(4'h2, 8'h00, 8'hFF);
      rd(4'h3, 8'h00, 8'h03);
      rd(4'h9, 8'h00, 8'hFF);
      f = falls;
      wr(4'h0, 8'h57);
      wr(4'h0, 8'hAF);
      k = $random(seed) & 3;
      for (int i = 0; i < 4; i++) begin
         wr(4'h1, codes[(i + k) % 4]);
         rd(4'h1, codes[(i + k) % 4], 8'hFF);
      end
      wr(4'h2, 8'hFF);
      rd(4'h2, 8'h80, 8'hFF);
      wr(4'h2, 8'h00);
      lowSupply <= 1'b1;
      repeat (60) @(posedge clk);
      chk1(falls == f, 1'b1);
      $display("done registers");
      wr(4'h1, 8'h99);
      lowSupplyValid <= 1'b1;
      waitR(1'b0);
      @(posedge clk);
      lowSupply <= 1'b0;
      lowSupplyValid <= 1'b0;
      waitR(1'b1);
      chk8(thresholdSel, 8'h99);
      rd(4'h2, 8'h04, 8'hFF);
      rd(4'h3, 8'h00, 8'h03);
      wr(4'h2, 8'hFF);
      rd(4'h2, 8'h04, 8'h7F);
      wr(4'h2, 8'h00);
      rd(4'h2, 8'h00, 8'hFF);
      wr(4'h1, 8'h12);
      waitR(1'b0);
      waitR(1'b1);
      chk8(thresholdSel, 8'h55);
      rd(4'h2, 8'h02, 8'hFF);
      wr(4'h2, 8'h00);
      rd(4'h2, 8'h00, 8'hFF);
      wr(4'h0, 8'h07);
      waitR(1'b0);
      waitR(1'b1);
      wr(4'h0, 8'hAF);
      rd(4'h2, 8'h01, 8'hFF);
      wr(4'h2, 8'h00);
      rd(4'h2, 8'h00, 8'hFF);
      $display("done faults");
      wr(4'h0, 8'hA8);
      wr(4'h4, 8'h01);
      tickAll <= 1'b1;
      f = falls;
      repeat (3) begin
         repeat (200) @(posedge clk);
         wr(4'h4, 8'h01);
      end
      chk1(falls == f, 1'b1);
      waitR(1'b0);
      chk1(n > 248 && n < 262, 1'b1);
      waitR(1'b1);
      rd(4'h3, 8'h01, 8'h01);
      $display("done timeout");
      for (int o = 0; o < 4; o++) begin
         oscSrc <= o[1:0];
         wr(4'h0, 8'hA8);
         wr(4'h4, 8'h02);
         rd(4'h3, 8'h0A, 8'h0A);
         f = falls;
         lowSupply <= 1'b1;
         lowSupplyValid <= 1'b1;
         repeat (20) @(posedge clk);
         lowSupply <= 1'b0;
         lowSupplyValid <= 1'b0;
         n = 0;
         while (pcSpClear !== 1'b1 && n < 400) begin
            @(negedge clk);
            n++;
         end
         chk1(pcSpClear, 1'b1);
         k = 0;
         while (pcSpClear === 1'b1 && k < 200) begin
            @(negedge clk);
            k++;
         end
         chk1(k >= setLo[o] && k <= setHi[o], 1'b1);
         repeat (140) @(posedge clk);
         chk1(falls == f, 1'b1);
         rd(4'h3, 8'h01, 8'h09);
      end
      tickAll <= 1'b0;
      wr(4'h0, 8'hAF);
      $display("done sleep");
      finish_test();
   end
endmodule
`default_nettype wire
